/* File: dram_ctrl_pkg.sv */
// ************************************************************
// shared constants and carriers for the page-mode memory controller
// ************************************************************
package dram_ctrl_pkg;

   localparam int CLOCK_PERIOD_NS = 50;

   // word address splits into row half (upper) and column half (lower)
   localparam int ROW_MSB = 15;
   localparam int ROW_LSB = 8;
   localparam int COL_MSB = 7;
   localparam int COL_LSB = 0;
   localparam int LOWER_LANE = 0;
   localparam int UPPER_LANE = 1;

   // power-up pause, a least time, so rounded up
   localparam int POWERUP_WAIT_US = 100;
   localparam logic [11:0] POWERUP_WAIT_CYCLES =
      12'((POWERUP_WAIT_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [3:0] INIT_REFRESH_COUNT = 4'h8;

   // every row within the period, a longest time, so rounded down
   localparam int REFRESH_PERIOD_MS = 4;
   localparam int REFRESH_ROWS = 256;
   localparam logic [8:0] REFRESH_INTERVAL_CYCLES =
      9'((REFRESH_PERIOD_MS * 1000000) / (REFRESH_ROWS * CLOCK_PERIOD_NS));
   localparam logic [8:0] REFRESH_MARGIN_CYCLES = 9'h010;

   // longest row strobe low time in page mode, rounded down
   localparam int PAGE_ROW_STROBE_WIDTH_NS = 100000;
   localparam logic [11:0] PAGE_ROW_STROBE_CYCLES = 12'(PAGE_ROW_STROBE_WIDTH_NS / CLOCK_PERIOD_NS);
   localparam logic [11:0] PAGE_CLOSE_MARGIN = 12'h010;

   // last count of the column strobe low cycles of one access, and of the row strobe low cycles of a refresh
   localparam logic [1:0] CAS_LOW_LAST = 2'h2;
   localparam logic [1:0] REF_RAS_LAST = 2'h1;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic lower_byte_write_n;
      logic upper_byte_write_n;
      logic oe_n;
      logic [7:0] addr;
      logic [15:0] dq_out;
      logic dq_oe_n;
   } dram_pins_t;

   localparam dram_pins_t PINS_IDLE = '{
      ras_n: 1'b1, cas_n: 1'b1, lower_byte_write_n: 1'b1, upper_byte_write_n: 1'b1,
      oe_n: 1'b1, addr: 8'h00, dq_out: 16'h0000, dq_oe_n: 1'b1};

   typedef struct packed {
      logic write;
      logic [1:0] byte_en;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_CAS, ST_PAGE, ST_PRE, ST_REF_CAS, ST_REF_RAS
   } ctrl_state_t;

endpackage

/* File: dram_refresh_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_timer
   import dram_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic refresh_done,
   output logic refresh_due,
   output logic init_done
);

   typedef struct packed {
      logic [11:0] wait_cnt;
      logic wait_done;
      logic [3:0] init_cnt;
      logic init_done;
      logic [8:0] tick_cnt;
      logic pending;
   } timer_reg_t;

   timer_reg_t t_reg;
   timer_reg_t t_next;
   logic tick;

   // ************************************************************
   // power-up pause, eight init refreshes, then periodic requests
   // ************************************************************
   always_comb begin
      t_next = t_reg;
      tick = 1'b0;
      if (!t_reg.wait_done) begin
         t_next.wait_cnt = t_reg.wait_cnt + 12'h001;
         if (t_reg.wait_cnt == POWERUP_WAIT_CYCLES - 12'h001) begin
            t_next.wait_done = 1'b1;
         end
      end else if (!t_reg.init_done) begin
         if (refresh_done) begin
            t_next.init_cnt = t_reg.init_cnt + 4'h1;
            if (t_reg.init_cnt == INIT_REFRESH_COUNT - 4'h1) begin
               t_next.init_done = 1'b1;
            end
         end
      end else begin
         // tick early by a margin so arbitration latency never stretches the period
         if (t_reg.tick_cnt == REFRESH_INTERVAL_CYCLES - REFRESH_MARGIN_CYCLES) begin
            t_next.tick_cnt = 9'h000;
            tick = 1'b1;
         end else begin
            t_next.tick_cnt = t_reg.tick_cnt + 9'h001;
         end
      end
      // a new tick wins over the clear by a served refresh
      t_next.pending = tick | (t_reg.pending & ~refresh_done);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign refresh_due = t_reg.wait_done & (~t_reg.init_done | t_reg.pending);
   assign init_done = t_reg.init_done;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_no_early_due: assert property (t_reg.wait_cnt < POWERUP_WAIT_CYCLES - 12'h001 |-> !refresh_due)
      else $error("refresh requested before power-up pause ended");
   a_pending_kept: assert property (t_reg.pending && !refresh_done |=> t_reg.pending)
      else $error("pending refresh dropped without service");

endmodule
`default_nettype wire

/* File: dram_page_controller.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - wait the power-up pause, then run eight refreshes before any access
// - refresh by column strobe before row strobe; init uses eight such cycles
// - hold write data around the falling column strobe of an early write
// - keep the row strobe low in page mode no longer than the limit
// - output enable stays high whenever the controller drives the data lines
// - byte strobes never stagger; both change on the same edge
// - refresh every row within the refresh period
// - lower strobe writes the low byte, upper the high; read uses oe low
// - further columns of an open row use column strobe cycles only
// - row half of the address first, then column half, on eight lines
module dram_page_controller
   import dram_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire mem_req_t req,
   output logic req_ready,
   output logic rd_valid,
   output logic [15:0] rd_data,
   output logic ready_for_access,
   output dram_pins_t dram,
   input wire logic [15:0] dq_in
);

   typedef struct packed {
      ctrl_state_t state;
      dram_pins_t pins;
      logic [7:0] row;
      logic write;
      logic [1:0] cnt;
      logic [11:0] page_cnt;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] rd_data;
      logic rd_valid;
      logic ref_done;
      mem_req_t held;
   } ctrl_reg_t;

   ctrl_reg_t s_reg;
   ctrl_reg_t s_next;
   logic refresh_due;
   logic init_done;
   logic req_fire;
   logic page_hit;

   function automatic logic [7:0] row_of(input logic [15:0] a);
      return a[ROW_MSB:ROW_LSB];
   endfunction

   function automatic logic [7:0] col_of(input logic [15:0] a);
      return a[COL_MSB:COL_LSB];
   endfunction

   // column setup: address, byte strobes, data drive and output enable in one step
   function automatic dram_pins_t col_setup(input dram_pins_t p, input mem_req_t r);
      dram_pins_t q;
      q = p;
      q.addr = col_of(r.addr);
      if (r.write) begin
         // both lanes fall together from one register, so they cannot stagger
         q.lower_byte_write_n = ~r.byte_en[LOWER_LANE];
         q.upper_byte_write_n = ~r.byte_en[UPPER_LANE];
         q.dq_out = r.wdata;
         q.dq_oe_n = 1'b0;
         q.oe_n = 1'b1;
      end else begin
         q.oe_n = 1'b0;
      end
      return q;
   endfunction

   // ************************************************************
   // refresh timing and power-up sequencing
   // ************************************************************
   dram_refresh_timer u_refresh_timer (
      .clock(clock),
      .rst_n(rst_n),
      .refresh_done(s_reg.ref_done),
      .refresh_due(refresh_due),
      .init_done(init_done)
   );

   // ************************************************************
   // request acceptance
   // ************************************************************
   // a page hit keeps the row open; refresh always wins the arbitration
   assign page_hit = (row_of(req.addr) == s_reg.row) && (s_reg.page_cnt < PAGE_ROW_STROBE_CYCLES - PAGE_CLOSE_MARGIN);
   assign req_ready = ((s_reg.state == ST_IDLE) && init_done && !refresh_due) ||
                      ((s_reg.state == ST_PAGE) && !refresh_due && page_hit);
   assign req_fire = req_valid & req_ready;

   // ************************************************************
   // strobe sequencer
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      // the pin data passes two flops before anything reads it
      s_next.sync1 = dq_in;
      s_next.sync2 = s_reg.sync1;
      s_next.rd_valid = 1'b0;
      s_next.ref_done = 1'b0;
      s_next.page_cnt = s_reg.pins.ras_n ? 12'h000 : s_reg.page_cnt + 12'h001;
      case (s_reg.state)
         ST_IDLE: begin
            if (refresh_due) begin
               s_next.pins.cas_n = 1'b0;
               s_next.state = ST_REF_CAS;
            end else if (req_fire) begin
               s_next.pins.ras_n = 1'b0;
               s_next.pins.addr = row_of(req.addr);
               s_next.row = row_of(req.addr);
               s_next.write = req.write;
               // the requester may move on once taken, so keep the column half here
               s_next.held = req;
               s_next.state = ST_ROW;
            end
         end
         ST_ROW: begin
            // row hold time is met before the column half replaces it
            s_next.pins = col_setup(s_reg.pins, s_reg.held);
            s_next.state = ST_COL;
         end
         ST_COL: begin
            // column strobe falls one cycle after the lanes, an early write
            s_next.pins.cas_n = 1'b0;
            s_next.cnt = 2'h0;
            s_next.state = ST_CAS;
         end
         ST_CAS: begin
            s_next.cnt = s_reg.cnt + 2'h1;
            if (s_reg.cnt == CAS_LOW_LAST) begin
               s_next.pins.cas_n = 1'b1;
               s_next.pins.lower_byte_write_n = 1'b1;
               s_next.pins.upper_byte_write_n = 1'b1;
               s_next.pins.oe_n = 1'b1;
               s_next.pins.dq_oe_n = 1'b1;
               if (!s_reg.write) begin
                  // sync2 holds the pins as seen at the end of the first low cycle
                  s_next.rd_data = s_reg.sync2;
                  s_next.rd_valid = 1'b1;
               end
               s_next.state = ST_PAGE;
            end
         end
         ST_PAGE: begin
            if (refresh_due || !page_hit && req_valid ||
                s_reg.page_cnt >= PAGE_ROW_STROBE_CYCLES - PAGE_CLOSE_MARGIN) begin
               s_next.pins.ras_n = 1'b1;
               s_next.state = ST_PRE;
            end else if (req_fire) begin
               s_next.write = req.write;
               s_next.pins = col_setup(s_reg.pins, req);
               s_next.state = ST_COL;
            end
         end
         ST_PRE: begin
            s_next.state = ST_IDLE;
         end
         ST_REF_CAS: begin
            s_next.pins.ras_n = 1'b0;
            s_next.cnt = 2'h0;
            s_next.state = ST_REF_RAS;
         end
         ST_REF_RAS: begin
            s_next.cnt = s_reg.cnt + 2'h1;
            s_next.pins.cas_n = 1'b1;
            if (s_reg.cnt == REF_RAS_LAST) begin
               s_next.pins.ras_n = 1'b1;
               s_next.ref_done = 1'b1;
               s_next.state = ST_PRE;
            end
         end
         default: begin
            s_next.state = ST_IDLE;
            s_next.pins = PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{state: ST_IDLE, pins: PINS_IDLE, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign dram = s_reg.pins;
   assign rd_data = s_reg.rd_data;
   assign rd_valid = s_reg.rd_valid;
   assign ready_for_access = init_done;

   // ************************************************************
   // checks
   // ************************************************************
   logic [3:0] cbr_seen;
   logic [11:0] ras_low_cnt;

   // helper counters seen only by the checks
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cbr_seen <= 4'h0;
         ras_low_cnt <= 12'h000;
      end else begin
         if ($fell(dram.ras_n) && !dram.cas_n && cbr_seen != INIT_REFRESH_COUNT) begin
            cbr_seen <= cbr_seen + 4'h1;
         end
         ras_low_cnt <= dram.ras_n ? 12'h000 : ras_low_cnt + 12'h001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence cbr_start;
      $fell(dram.cas_n) && dram.ras_n;
   endsequence

   sequence write_col_fall;
      $fell(dram.cas_n) && !dram.ras_n && (!dram.lower_byte_write_n || !dram.upper_byte_write_n);
   endsequence

   a_cbr_order: assert property (cbr_start |=> $fell(dram.ras_n) && !dram.cas_n)
      else $error("row strobe did not follow column strobe in refresh");
   a_init_first: assert property ($fell(dram.ras_n) && dram.cas_n |-> cbr_seen == INIT_REFRESH_COUNT)
      else $error("access before eight init refreshes");
   a_lower_together: assert property ($fell(dram.lower_byte_write_n) |->
      $fell(dram.upper_byte_write_n) || dram.upper_byte_write_n)
      else $error("lower byte strobe staggered");
   a_upper_together: assert property ($fell(dram.upper_byte_write_n) |->
      $fell(dram.lower_byte_write_n) || dram.lower_byte_write_n)
      else $error("upper byte strobe staggered");
   a_oe_off_drive: assert property (!dram.dq_oe_n |-> dram.oe_n)
      else $error("data driven while device outputs enabled");
   a_read_oe_low: assert property ($fell(dram.cas_n) && !dram.ras_n && !s_reg.write |->
      !dram.oe_n && dram.lower_byte_write_n && dram.upper_byte_write_n)
      else $error("read column cycle without output enable");
   a_row_addr: assert property ($fell(dram.ras_n) && dram.cas_n |-> dram.addr == s_reg.row)
      else $error("row half not on address lines at row strobe");
   a_early_write: assert property (write_col_fall |-> $stable(dram.lower_byte_write_n) &&
      $stable(dram.upper_byte_write_n) && !dram.dq_oe_n[*3])
      else $error("write lanes not set up and held around column strobe");
   a_read_return: assert property ($fell(dram.cas_n) && !dram.ras_n && !dram.oe_n |-> ##3 rd_valid)
      else $error("read data not returned three cycles after column strobe");
   a_page_limit: assert property (ras_low_cnt <= PAGE_ROW_STROBE_CYCLES)
      else $error("row strobe held low too long");
   a_refresh_served: assert property ($rose(refresh_due) |-> ##[1:40] cbr_start)
      else $error("refresh not started in time");

endmodule
`default_nettype wire

/* File: dram_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// behavioural memory device facing the controller pins
// ************************************************************
module dram_device_model
   import dram_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire dram_pins_t pins,
   output logic [15:0] dq,
   output var int violations
);
   logic [15:0] mem [0:65535];
   logic [7:0] row_l = 8'h00;
   logic [7:0] col_l = 8'h00;
   logic [15:0] last_dq = 16'h0000;
   logic rd_drive;
   int cbr_seen;
   int since_reset;
   int ras_low;
   int since_ref;
   dram_pins_t prev;

   initial violations = 0;

   // row latched on row strobe fall, column on column strobe fall
   always @(negedge pins.ras_n) row_l = pins.addr;
   always @(negedge pins.cas_n) begin
      col_l = pins.addr;
      // early write: lanes captured at the column strobe fall
      if (!pins.ras_n && !pins.lower_byte_write_n) mem[{row_l, pins.addr}][7:0] = dq[7:0];
      if (!pins.ras_n && !pins.upper_byte_write_n) mem[{row_l, pins.addr}][15:8] = dq[15:8];
   end

   // outputs only in a read; early writes leave them off
   assign rd_drive = !pins.ras_n && !pins.cas_n && !pins.oe_n
      && pins.lower_byte_write_n && pins.upper_byte_write_n;
   // released lines toggle so a stale value can never look right
   assign dq = !pins.dq_oe_n ? pins.dq_out : rd_drive ? mem[{row_l, col_l}] : ~last_dq;
   always @(posedge clock) last_dq <= dq;

   // protocol watch on the controller side
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         since_reset <= 0;
         cbr_seen <= 0;
         ras_low <= 0;
         since_ref <= 0;
         prev <= PINS_IDLE;
      end else begin
         prev <= pins;
         since_reset <= since_reset + 1;
         ras_low <= pins.ras_n ? 0 : ras_low + 1;
         since_ref <= since_ref + 1;
         if (prev.ras_n && !pins.ras_n) begin
            if (!pins.cas_n) begin
               cbr_seen <= cbr_seen + 1;
               since_ref <= 0;
            end else if (since_reset < 2000 || cbr_seen < 8) violations = violations + 1;
         end
         if (!pins.ras_n && ras_low >= 2000) violations = violations + 1;
         if (cbr_seen >= 8 && since_ref > 312) violations = violations + 1;
         if (!pins.dq_oe_n && !pins.oe_n) violations = violations + 1;
         if ((prev.lower_byte_write_n != pins.lower_byte_write_n)
            != (prev.upper_byte_write_n != pins.upper_byte_write_n)
            && !pins.lower_byte_write_n && !pins.upper_byte_write_n) violations = violations + 1;
         // a strobe falling under a low column strobe would be a late write, whose outputs are not defined
         if (!prev.cas_n && !pins.cas_n && ((prev.lower_byte_write_n && !pins.lower_byte_write_n)
            || (prev.upper_byte_write_n && !pins.upper_byte_write_n))) violations = violations + 1;
      end
   end
endmodule
`default_nettype wire

/* File: dram_page_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_page_controller_tb_top
   import dram_ctrl_pkg::*;
();
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   mem_req_t req = '0;
   logic req_ready;
   logic rd_valid;
   logic [15:0] rd_data;
   logic ready_for_access;
   dram_pins_t dram;
   logic [15:0] dq;
   int violations;
   int fail_count = 0;
   int checks_done = 0;

   // ************************************************************
   // clock, design and device
   // ************************************************************
   always #25 clock = ~clock;

   dram_page_controller i_dram_page_controller (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .ready_for_access(ready_for_access), .dram(dram), .dq_in(dq));
   dram_device_model i_dram_device_model (.clock(clock), .rst_n(rst_n), .pins(dram), .dq(dq),
      .violations(violations));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic test_done;
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one request; lat counts edges from taking to read data
   task automatic request(input logic wr, input logic [1:0] be, input logic [15:0] a,
      input logic [15:0] d, output int lat);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req = '{write: wr, byte_en: be, addr: a, wdata: d};
      // ready depends on the new address; let it settle before looking
      #1;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      if (n >= 400) begin
         fail_count++;
         test_done();
      end
      @(negedge clock);
      req_valid = 1'b0;
      lat = 1;
      while (!wr && rd_valid !== 1'b1 && lat < 20) begin
         @(negedge clock);
         lat++;
      end
      if (lat >= 20) begin
         fail_count++;
         test_done();
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      repeat (4) @(negedge clock);
      check(32'(dram), 32'(PINS_IDLE));
      check(32'({rd_valid, req_ready, ready_for_access}), 32'h0);
   endtask

   task automatic t_init;
      int n;
      n = 0;
      while (ready_for_access !== 1'b1 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      check(32'(n >= 2032 && n < 3000), 32'h1);
   endtask

   // lane writes merge into one word; empty mask changes nothing
   task automatic t_lanes;
      int lat;
      request(1'b1, 2'b11, 16'h1234, 16'h1234, lat);
      request(1'b1, 2'b01, 16'h1234, 16'hAB55, lat);
      request(1'b1, 2'b10, 16'h1234, 16'hCC00, lat);
      request(1'b1, 2'b00, 16'h1234, 16'hFFFF, lat);
      request(1'b0, 2'b11, 16'h1234, 16'h0000, lat);
      check(32'(rd_data), 32'h0000CC55);
      // open row, no refresh near: a page hit returns in five cycles
      check(32'(lat), 32'h5);
   endtask

   // other row forces a close and a fresh activation
   task automatic t_miss;
      int lat;
      request(1'b1, 2'b11, 16'h5601, 16'hA5A5, lat);
      request(1'b0, 2'b11, 16'h1234, 16'h0000, lat);
      check(32'(lat), 32'h6);
      check(32'(rd_data), 32'h0000CC55);
      request(1'b1, 2'b11, 16'h5602, 16'h0F0F, lat);
      request(1'b0, 2'b11, 16'h5601, 16'h0000, lat);
      check(32'(rd_data), 32'h0000A5A5);
      request(1'b0, 2'b11, 16'h5602, 16'h0000, lat);
      check(32'(rd_data), 32'h00000F0F);
   endtask

   // one row kept busy past the page limit, refreshes interleaved
   task automatic t_page;
      int lat;
      for (int i = 0; i < 256; i++) begin
         request(1'b1, 2'b11, {8'h77, 8'(i)}, {~8'(i), 8'(i)}, lat);
      end
      for (int i = 0; i < 256; i++) begin
         request(1'b0, 2'b11, {8'h77, 8'(i)}, 16'h0000, lat);
         check(32'(rd_data), 32'({~8'(i), 8'(i)}));
         check(32'(lat <= 6), 32'h1);
      end
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      t_reset();
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      t_init();
      t_lanes();
      t_miss();
      t_page();
      repeat (10) @(negedge clock);
      check(32'(violations), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
